// ===== logic/s2p_defs.svh
// register offsets, field positions, reset values and byte and buffer sizes of the converter
`ifndef S2P_DEFS_SVH
`define S2P_DEFS_SVH

// wishbone byte addresses, one word each
`define S2P_CTRL_ADDR 8'h00
`define S2P_STATUS_ADDR 8'h04
`define S2P_FIFO_ADDR 8'h08
`define S2P_LAST_ADDR 8'h0C

// control field positions and reset value
`define S2P_CTRL_CAPTURE 0
`define S2P_CTRL_FLUSH 1
`define S2P_CTRL_RESET 2'h1

// status field positions
`define S2P_ST_READY 0
`define S2P_ST_CNT_LO 1
`define S2P_ST_EMPTY 4
`define S2P_ST_FULL 5
`define S2P_ST_OVF 6

// byte geometry, buffering and pin synchroniser width
`define S2P_BYTE_W 8
`define S2P_CNT_W 3
`define S2P_LAST_BIT 3'h7
`define S2P_FIFO_DEPTH 16
`define S2P_SYNC_W 6

`endif

// ===== logic/s2p_pkg.sv
// types shared by the converter files
package s2p_pkg;
   // one assembled byte
   typedef logic [7:0] byte_t;
   // bit position inside the byte being assembled
   typedef logic [2:0] bit_cnt_t;
   // wishbone slave progress
   typedef enum logic [0:0] {BUS_IDLE, BUS_ACK} bus_state_t;
endpackage : s2p_pkg

// ===== logic/pin_sync.sv
// two-stage synchroniser for a group of pin inputs
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // raw pins and synchronised levels
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] pin_sync_out
);
   // first stage, read by the second stage only
   logic [WIDTH-1:0] meta_q;
   // second stage
   logic [WIDTH-1:0] stable_q;

   // one generate slice per pin
   genvar gi;
   generate
      for (gi = 0; gi < WIDTH; gi = gi + 1)
      begin : g_bit
         always_ff @(posedge core_clk)
         begin
            if (!rst_b)
            begin
               meta_q[gi] <= 1'b0;
               stable_q[gi] <= 1'b0;
            end
            else
            begin
               meta_q[gi] <= pin_in[gi];
               stable_q[gi] <= meta_q[gi];
            end
         end
      end
   endgenerate

   assign pin_sync_out = stable_q;
endmodule : pin_sync
`default_nettype wire

// ===== logic/byte_fifo.sv
// small synchronous fifo holding assembled bytes
`timescale 1ns/10ps
`default_nettype none
module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // flush drops every stored word
   input wire logic flush,
   // filling side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // draining side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   // fill level
   output logic [$clog2(DEPTH):0] level
);
   localparam int AW = $clog2(DEPTH);
   // storage
   logic [WIDTH-1:0] mem_q [DEPTH];
   // pointers and count
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   // handshakes
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   // registered head word and the slot that becomes the head next
   logic [WIDTH-1:0] head_q;
   wire [AW-1:0] rd_next = pop ? rd_q + 1'b1 : rd_q;
   // a write into the next head slot must be forwarded
   wire head_bypass = push && (wr_q == rd_next);

   assign in_ready = (cnt_q != DEPTH[AW:0]);
   assign out_valid = (cnt_q != '0);
   assign out_data = head_q;
   assign level = cnt_q;

   // write port, no reset needed on storage
   always_ff @(posedge core_clk)
   begin
      if (push)
         mem_q[wr_q] <= in_data;
   end

   // head register: read data come from a flop; the array read sees old data,
   // so a push into the slot about to become the head is forwarded
   always_ff @(posedge core_clk)
   begin
      if (head_bypass)
         head_q <= in_data;
      else
         head_q <= mem_q[rd_next];
   end

   // pointer and count bookkeeping
   always_ff @(posedge core_clk)
   begin
      if (!rst_b || flush)
      begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end
      else
      begin
         if (push)
            wr_q <= wr_q + 1'b1;
         if (pop)
            rd_q <= rd_q + 1'b1;
         // both at once leaves the count alone
         if (push && !pop)
            cnt_q <= cnt_q + 1'b1;
         else if (pop && !push)
            cnt_q <= cnt_q - 1'b1;
      end
   end
endmodule : byte_fifo
`default_nettype wire

// ===== logic/disk_serial_to_parallel_converter.sv
// serial to parallel byte converter with wishbone access and byte fifo
//
// Design decisions made here: the Wishbone register port and the placing of the registers.
`include "s2p_defs.svh"
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// RQ1: rising serial clock shifts data into register
// RQ2: falling serial clock advances the bit counter
// RQ3: sync start high holds counter cleared
// RQ4: source raises sync start before first bit
// RQ5: source drops sync start in clock low
// RQ6: eighth falling edge sets flag, loads byte
// RQ7: output byte register separate from shifter
// RQ8: flag held cleared while byte clear low
// RQ9: host releases byte clear before next byte
// RQ10: byte clear touches only the ready flag
// RQ11: serial out comes from last shifter stage
// RQ12: shift clock out is inverted serial clock
// RQ13: enable low floats flag, serial, shift clock
// RQ14: inhibit input also holds counter, pulled up
// RQ15: host strobes byte clear on each read
// RQ16: host clears flag once after power up
// RQ17: counter wraps modulo eight between bytes
module disk_serial_to_parallel_converter (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // serial pins from the read channel
   input wire logic serial_clk,
   input wire logic serial_data,
   input wire logic sync_start,
   input wire logic counter_inhibit_n,
   // host pins
   input wire logic byte_clear_n,
   input wire logic output_enable,
   output logic [7:0] parallel_byte_out,
   // three-state outputs, enable low while driven
   output logic byte_ready_flag,
   output logic byte_ready_flag_oe_n,
   output logic serial_out,
   output logic serial_out_oe_n,
   output logic shift_clock_out,
   output logic shift_clock_out_oe_n,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o
);
   // synchronised pin levels
   logic [`S2P_SYNC_W-1:0] pins_s;
   wire sclk_s = pins_s[0];
   wire sdata_s = pins_s[1];
   wire start_s = pins_s[2];
   wire inhibit_n_s = pins_s[3];
   wire clear_n_s = pins_s[4];
   wire enable_s = pins_s[5];

   // previous serial clock level, for edge finding
   logic sclk_prev_q;
   // shift register, bit counter, output byte
   s2p_pkg::byte_t shift_q;
   s2p_pkg::bit_cnt_t cnt_q;
   s2p_pkg::byte_t byte_q;
   // ready latch
   logic ready_q;
   // software control and sticky overflow
   logic [1:0] ctrl_q;
   logic ovf_q;
   // bus state and registered read data
   s2p_pkg::bus_state_t bus_q;
   logic [31:0] rdat_q;
   // fifo wiring
   logic fifo_ready;
   logic fifo_valid;
   logic [7:0] fifo_data;
   logic [4:0] fifo_level;
   // bus-side pop strobe, decoded below with the other bus terms
   logic fifo_pop;

   // all pins cross into core_clk before use
   pin_sync #(
      .WIDTH(`S2P_SYNC_W)
   ) u_sync (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .pin_in({output_enable, byte_clear_n, counter_inhibit_n, sync_start, serial_data,
         serial_clk}),
      .pin_sync_out(pins_s)
   );

   // edge decode of the synchronised serial clock
   wire sclk_rise = sclk_s && !sclk_prev_q;
   wire sclk_fall = !sclk_s && sclk_prev_q;
   // counter hold: start high or inhibit pulled low
   wire cnt_hold = start_s || !inhibit_n_s; // [RQ3] [RQ14]
   // byte complete on the eighth counting edge
   wire byte_done = sclk_fall && !cnt_hold && (cnt_q == `S2P_LAST_BIT); // [RQ6]
   // fifo push, gated by software capture enable
   wire fifo_push = byte_done && ctrl_q[`S2P_CTRL_CAPTURE];
   // a byte lost because the fifo had no room
   wire fifo_drop = fifo_push && !fifo_ready;

   // serial clock history
   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
         sclk_prev_q <= 1'b0;
      else
         sclk_prev_q <= sclk_s;
   end

   // shifter: msb first, last stage feeds serial out
   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
         shift_q <= 8'h00;
      else if (sclk_rise)
         shift_q <= {shift_q[6:0], sdata_s}; // [RQ1]
   end

   // bit counter on falling edges, wraps without a new start
   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
         cnt_q <= 3'h0;
      else if (sclk_fall)
      begin
         if (cnt_hold)
            cnt_q <= 3'h0; // [RQ3]
         else
            cnt_q <= cnt_q + 3'h1; // [RQ2] [RQ17]
      end
   end

   // output byte only changes on completion, never by byte clear
   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
         byte_q <= 8'h00;
      else if (byte_done)
         byte_q <= shift_q; // [RQ6] [RQ7] [RQ10]
   end

   // ready latch: a low clear holds it down, even against a new byte
   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
         ready_q <= 1'b0;
      else if (!clear_n_s)
         ready_q <= 1'b0; // [RQ8]
      else if (byte_done)
         ready_q <= 1'b1; // [RQ6]
   end

   // pin outputs, all registered
   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         parallel_byte_out <= 8'h00;
         byte_ready_flag <= 1'b0;
         serial_out <= 1'b0;
         shift_clock_out <= 1'b1;
         byte_ready_flag_oe_n <= 1'b1;
         serial_out_oe_n <= 1'b1;
         shift_clock_out_oe_n <= 1'b1;
      end
      else
      begin
         parallel_byte_out <= byte_q; // [RQ7]
         byte_ready_flag <= ready_q;
         serial_out <= shift_q[7]; // [RQ11]
         shift_clock_out <= !sclk_s; // [RQ12]
         byte_ready_flag_oe_n <= !enable_s; // [RQ13]
         serial_out_oe_n <= !enable_s; // [RQ13]
         shift_clock_out_oe_n <= !enable_s; // [RQ13] [RQ12]
      end
   end

   // bytes queue up for software; drops are flagged, the stream cannot stall
   byte_fifo #(
      .WIDTH(`S2P_BYTE_W),
      .DEPTH(`S2P_FIFO_DEPTH)
   ) u_fifo (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .flush(ctrl_q[`S2P_CTRL_FLUSH]),
      .in_valid(fifo_push),
      .in_ready(fifo_ready),
      .in_data(shift_q),
      .out_valid(fifo_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_data),
      .level(fifo_level)
   );

   // wishbone decode
   wire bus_req = wb_cyc_i && wb_stb_i && (bus_q == s2p_pkg::BUS_IDLE);
   wire hit_ctrl = (wb_adr_i == `S2P_CTRL_ADDR);
   wire hit_status = (wb_adr_i == `S2P_STATUS_ADDR);
   wire hit_fifo = (wb_adr_i == `S2P_FIFO_ADDR);
   wire hit_last = (wb_adr_i == `S2P_LAST_ADDR);
   wire wr_ctrl = bus_req && wb_we_i && hit_ctrl && wb_sel_i[0];
   wire wr_ovf_clr = bus_req && wb_we_i && hit_status && wb_sel_i[0] && wb_dat_i[`S2P_ST_OVF];
   assign fifo_pop = bus_req && !wb_we_i && hit_fifo && fifo_valid;
   // status word
   wire [31:0] status_word = {25'h0, ovf_q, !fifo_ready, !fifo_valid, cnt_q, ready_q};
   // read mux; unmapped reads return zero
   wire [31:0] rd_mux = hit_ctrl ? {30'h0, ctrl_q} :
      hit_status ? status_word :
      hit_fifo ? {24'h0, fifo_valid ? fifo_data : 8'h00} :
      hit_last ? {24'h0, byte_q} : 32'h0;

   // one-cycle ack, then one idle cycle
   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         bus_q <= s2p_pkg::BUS_IDLE;
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end
      else
      begin
         case (bus_q)
            s2p_pkg::BUS_IDLE:
            begin
               wb_ack_o <= bus_req;
               if (bus_req)
               begin
                  bus_q <= s2p_pkg::BUS_ACK;
                  wb_dat_o <= wb_we_i ? 32'h0 : rd_mux;
               end
            end
            s2p_pkg::BUS_ACK:
            begin
               wb_ack_o <= 1'b0;
               bus_q <= s2p_pkg::BUS_IDLE;
            end
            default:
            begin
               wb_ack_o <= 1'b0;
               bus_q <= s2p_pkg::BUS_IDLE;
            end
         endcase
      end
   end

   // control register; flush bit clears itself after one cycle
   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
         ctrl_q <= `S2P_CTRL_RESET;
      else if (wr_ctrl)
         ctrl_q <= wb_dat_i[1:0];
      else
         ctrl_q[`S2P_CTRL_FLUSH] <= 1'b0;
   end

   // sticky overflow, a new drop wins over the clear
   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
         ovf_q <= 1'b0;
      else if (fifo_drop)
         ovf_q <= 1'b1;
      else if (wr_ovf_clr)
         ovf_q <= 1'b0;
   end

   // checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   chk_shift_on_rise: assert property ( // [RQ1]
      sclk_rise |=> shift_q == {$past(shift_q[6:0]), $past(sdata_s)})
      else $error("shifter missed a rising edge");
   chk_count_on_fall: assert property ( // [RQ2]
      sclk_fall && !cnt_hold && cnt_q != 3'h7 |=> cnt_q == $past(cnt_q) + 3'h1)
      else $error("counter did not advance");
   chk_start_holds: assert property (sclk_fall && cnt_hold |=> cnt_q == 3'h0) // [RQ3]
      else $error("counter not held by start");
   chk_byte_load: assert property ( // [RQ6]
      byte_done |=> byte_q == $past(shift_q) ##1 parallel_byte_out == $past(shift_q, 2))
      else $error("byte not loaded");
   chk_flag_set: assert property (byte_done && clear_n_s |=> ready_q ##1 byte_ready_flag) // [RQ6]
      else $error("ready flag not set");
   chk_byte_stable: assert property (!byte_done |=> byte_q == $past(byte_q)) // [RQ7]
      else $error("output byte changed mid-byte");
   chk_clear_level: assert property (!clear_n_s |=> !ready_q ##1 !byte_ready_flag) // [RQ8]
      else $error("flag not held cleared");
   chk_clear_isolated: assert property ( // [RQ10]
      !clear_n_s && !sclk_rise |=> shift_q == $past(shift_q))
      else $error("byte clear touched shifter");
   chk_serial_out: assert property (1'b1 |=> serial_out == $past(shift_q[7])) // [RQ11]
      else $error("serial out not last stage");
   chk_shift_clock: assert property (1'b1 |=> shift_clock_out == !$past(sclk_s)) // [RQ12]
      else $error("shift clock not inverted");
   chk_enable_float: assert property ( // [RQ13]
      !enable_s |=> byte_ready_flag_oe_n && serial_out_oe_n && shift_clock_out_oe_n)
      else $error("outputs not floated");
   chk_inhibit_hold: assert property (sclk_fall && !inhibit_n_s |=> cnt_q == 3'h0) // [RQ14]
      else $error("inhibit did not hold counter");
   chk_wrap_eight: assert property (byte_done |=> cnt_q == 3'h0) // [RQ17]
      else $error("counter did not wrap");

   cov_byte_done: cover property (byte_done);
   cov_back_to_back: cover property (byte_done ##[1:200] byte_done);
   cov_fifo_drop: cover property (fifo_drop);
   cov_clear_vs_done: cover property (byte_done && !clear_n_s);
endmodule : disk_serial_to_parallel_converter
`default_nettype wire

// ===== test/read_src.sv
// serial read channel model driving the converter pins
`timescale 1ns/10ps
`default_nettype none
module read_src (
   // clock
   input wire logic core_clk,
   // frame request
   input wire logic go,
   input wire logic with_sync,
   input wire logic two,
   input wire logic [15:0] word,
   output logic busy,
   // serial pins
   output logic serial_clk,
   output logic serial_data,
   output logic sync_start
);
   logic [7:0] step_q; // core cycles into the frame
   logic [7:0] end_q; // last step of the frame
   logic last_q; // last bit put on the line
   // bit period p carries word bit 16-p, msb first
   wire logic [4:0] idx = 5'h10 - step_q[7:3];

   // no reset pin on this side, so start idle
   initial
   begin
      busy = 1'b0;
      step_q = 8'h00;
      end_q = 8'h00;
      last_q = 1'b0;
      sync_start = 1'b0;
   end

   // clock stands low between frames, 4 core cycles per phase
   assign serial_clk = busy & step_q[2];
   // released line shows the inverse of the last bit
   assign serial_data = busy ? word[idx[3:0]] : ~last_q;

   // frame sequencer; period 0 is the sync period
   always @(posedge core_clk)
   begin
      if (!busy && go)
      begin
         busy <= 1'b1;
         step_q <= with_sync ? 8'h00 : 8'h08;
         end_q <= two ? 8'h87 : 8'h47;
         sync_start <= with_sync;
      end
      else if (busy)
      begin
         step_q <= step_q + 8'h01;
         last_q <= serial_data;
         busy <= (step_q != end_q);
         // drop only in the low phase after a full cycle
         if (step_q == 8'h0A)
            sync_start <= 1'b0;
      end
   end
endmodule : read_src
`default_nettype wire

// ===== test/tb_disk_serial_to_parallel_converter.sv
// self-checking bench for the serial to parallel converter
`include "s2p_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module tb_disk_serial_to_parallel_converter;
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   logic serial_clk, serial_data, sync_start, busy;
   logic counter_inhibit_n = 1'b1; // open pin, pulled up
   logic byte_clear_n = 1'b1;
   logic output_enable = 1'b1;
   logic go = 1'b0, with_sync = 1'b0, two = 1'b0;
   logic [15:0] word = 16'h0000;
   logic [7:0] parallel_byte_out;
   logic byte_ready_flag, byte_ready_flag_oe_n, serial_out, serial_out_oe_n;
   logic shift_clock_out, shift_clock_out_oe_n, wb_ack_o;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h00000000, wb_dat_o, rd;
   int n_fail = 0, check_count = 0;

   // 10 MHz core clock
   always #50 core_clk = ~core_clk;

   disk_serial_to_parallel_converter dut_u (.core_clk, .rst_b, .serial_clk, .serial_data,
      .sync_start, .counter_inhibit_n, .byte_clear_n, .output_enable, .parallel_byte_out,
      .byte_ready_flag, .byte_ready_flag_oe_n, .serial_out, .serial_out_oe_n,
      .shift_clock_out, .shift_clock_out_oe_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
      .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o);

   read_src src_u (.core_clk, .go, .with_sync, .two, .word, .busy, .serial_clk,
      .serial_data, .sync_start);

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : tally_and_finish

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic cycles(input int n);
      repeat (n) @(posedge core_clk);
   endtask : cycles

   // one classic wishbone cycle, held until ack is sampled
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
      int n = 0;
      @(posedge core_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= wd;
      do
      begin
         @(posedge core_clk);
         n++;
      end
      while (wb_ack_o !== 1'b1 && n < 20);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      check("wb ack", 1, wb_ack_o);
      if (wb_ack_o !== 1'b1)
         tally_and_finish();
   endtask : wb

   task automatic rd_chk(input string what, input logic [7:0] adr, input logic [31:0] exp);
      wb(1'b0, adr, 32'h00000000);
      check(what, exp, rd);
   endtask : rd_chk

   task automatic start(input logic s, input logic t, input logic [15:0] w);
      @(posedge core_clk);
      go <= 1'b1;
      with_sync <= s;
      two <= t;
      word <= w;
      @(posedge core_clk);
      go <= 1'b0;
      // the model raises busy at the edge above; let it settle before polling
      @(posedge core_clk);
   endtask : start

   // bounded wait for the frame end plus pin latency
   task automatic finish_frame;
      int n = 0;
      while (busy === 1'b1 && n < 400)
      begin
         @(posedge core_clk);
         n++;
      end
      check("frame end", 0, busy);
      if (busy !== 1'b0)
         tally_and_finish();
      cycles(8);
   endtask : finish_frame

   task automatic send(input logic s, input logic [7:0] b);
      start(s, 1'b0, {b, 8'h00});
      finish_frame();
   endtask : send

   task automatic clr_pulse;
      byte_clear_n <= 1'b0;
      cycles(3);
      byte_clear_n <= 1'b1;
      cycles(3);
   endtask : clr_pulse

   task automatic t_enable;
      check("shift clk idle", 1, shift_clock_out);
      check("oe on", 0, {byte_ready_flag_oe_n, serial_out_oe_n, shift_clock_out_oe_n});
      output_enable <= 1'b0;
      cycles(4);
      check("oe off", 3'h7, {byte_ready_flag_oe_n, serial_out_oe_n, shift_clock_out_oe_n});
      output_enable <= 1'b1;
      cycles(4);
      $display("test enable done");
   endtask : t_enable

   task automatic t_single;
      clr_pulse();
      check("flag after clear", 0, byte_ready_flag);
      send(1'b1, 8'hA5);
      check("byte", 8'hA5, parallel_byte_out);
      check("flag set", 1, byte_ready_flag);
      check("serial out", 1, serial_out);
      rd_chk("last byte", `S2P_LAST_ADDR, 32'h000000A5);
      rd_chk("fifo pop", `S2P_FIFO_ADDR, 32'h000000A5);
      $display("test single done");
   endtask : t_single

   task automatic t_two;
      int n = 0;
      clr_pulse();
      start(1'b0, 1'b1, 16'h3CC3);
      while (byte_ready_flag !== 1'b1 && n < 400)
      begin
         @(posedge core_clk);
         n++;
      end
      check("first flag", 1, byte_ready_flag);
      if (byte_ready_flag !== 1'b1)
         tally_and_finish();
      check("first byte", 8'h3C, parallel_byte_out);
      clr_pulse();
      check("flag cleared", 0, byte_ready_flag);
      check("byte held", 8'h3C, parallel_byte_out);
      finish_frame();
      check("second byte", 8'hC3, parallel_byte_out);
      check("flag again", 1, byte_ready_flag);
      $display("test two bytes done");
   endtask : t_two

   task automatic t_hold_clear;
      byte_clear_n <= 1'b0;
      send(1'b1, 8'h5A);
      check("flag held", 0, byte_ready_flag);
      check("byte under clear", 8'h5A, parallel_byte_out);
      check("serial out low", 0, serial_out);
      byte_clear_n <= 1'b1;
      cycles(4);
      check("flag stays", 0, byte_ready_flag);
      counter_inhibit_n <= 1'b0;
      send(1'b0, 8'h81);
      check("inhibited byte", 8'h5A, parallel_byte_out);
      check("shift runs", 1, serial_out);
      counter_inhibit_n <= 1'b1;
      $display("test hold clear done");
   endtask : t_hold_clear

   task automatic t_fifo;
      wb(1'b1, `S2P_CTRL_ADDR, 32'h00000003);
      rd_chk("unmapped", 8'h10, 32'h00000000);
      for (int i = 0; i < 17; i++)
         send(i == 0, 8'h10 + i[7:0]);
      wb(1'b0, `S2P_STATUS_ADDR, 32'h00000000);
      check("full", 1, rd[`S2P_ST_FULL]);
      check("overflow", 1, rd[`S2P_ST_OVF]);
      for (int i = 0; i < 16; i++)
         rd_chk("fifo order", `S2P_FIFO_ADDR, 32'h10 + i);
      rd_chk("empty pop", `S2P_FIFO_ADDR, 32'h00000000);
      wb(1'b1, `S2P_STATUS_ADDR, 32'h00000040);
      wb(1'b0, `S2P_STATUS_ADDR, 32'h00000000);
      check("empty", 1, rd[`S2P_ST_EMPTY]);
      check("ovf cleared", 0, rd[`S2P_ST_OVF]);
      $display("test fifo done");
   endtask : t_fifo

   // main sequence
   initial
   begin
      cycles(10);
      check("reset flag", 0, byte_ready_flag);
      rst_b <= 1'b1;
      cycles(4);
      rd_chk("ctrl reset", `S2P_CTRL_ADDR, 32'h00000001);
      t_enable();
      t_single();
      t_two();
      t_hold_clear();
      t_fifo();
      tally_and_finish();
   end
endmodule : tb_disk_serial_to_parallel_converter
`default_nettype wire
